// ===== rtl/ccd_clock_ctrl.sv
// cpu clock divider, legacy halving and clock output pin control
`default_nettype none
module ccd_clock_ctrl (
   input  wire logic                       ref_clk_in,
   input  wire logic                       rst_in,
   // configuration byte, steady from reset release
   input  wire logic [ccd_pkg::DATA_W-1:0] user_config_byte_one_in,
   // register port
   input  wire logic [ccd_pkg::ADDR_W-1:0] addr_in,
   input  wire logic [ccd_pkg::DATA_W-1:0] wr_data_in,
   input  wire logic                       wr_in,
   input  wire logic                       rd_in,
   output logic      [ccd_pkg::DATA_W-1:0] rd_data_out,
   // power state from the core
   input  wire logic                       idle_in,
   input  wire logic                       power_down_in,
   // clock enables toward core and peripherals
   output logic                            cpu_clk_en_out,
   output logic                            periph_clk_en_out,
   output logic                            machine_cycle_out,
   // port latch side of port2_bit0 and port2_bit1
   input  wire logic                       port2_bit0_drive_in,
   input  wire logic                       port2_bit0_oe_in,
   input  wire logic                       port2_bit1_drive_in,
   input  wire logic                       port2_bit1_oe_in,
   output logic                            port2_bit0_out,
   output logic                            port2_bit1_out,
   // osc_out_pin, shared with port2_bit0 and clock_out_pin
   input  wire logic                       osc_out_pin_in,
   output logic                            osc_out_pin_out,
   output logic                            osc_out_pin_oe_out,
   // osc_in_pin, shared with port2_bit1
   input  wire logic                       osc_in_pin_in,
   output logic                            osc_in_pin_out,
   output logic                            osc_in_pin_oe_out,
   // mode register image for the other port logic
   output logic      [ccd_pkg::DATA_W-1:0] port2_mode_one_out
);
   ccd_pkg::ccd_state_t state;

   logic [ccd_pkg::OSC_W-1:0]  osc_mode;
   logic                       legacy_timing_halve;
   logic [ccd_pkg::DATA_W-1:0] cpu_clock_divider_value;
   logic [ccd_pkg::DATA_W-1:0] port2_mode_one;
   logic [ccd_pkg::DATA_W-1:0] status;
   logic [ccd_pkg::DATA_W-1:0] next_rd_data;
   logic [2:0]                 cko_phase;
   logic [2:0]                 mcyc_count;
   logic                       clock_out_level;
   logic                       clock_out_allowed;
   logic                       clock_out_enable;
   logic                       clock_out_on;
   logic                       crystal;
   logic                       running;
   logic                       cpu_tick;

   // start-up: sample the configuration, then run
   // one cycle to take the configuration byte; pins stay released
   // until the run state is reached
   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         state <= ccd_pkg::ST_LOAD;
      end else begin
         case (state)
            ccd_pkg::ST_LOAD: state <= ccd_pkg::ST_RUN;
            ccd_pkg::ST_RUN:  state <= ccd_pkg::ST_RUN;
            default:          state <= ccd_pkg::ST_LOAD;
         endcase
      end
   end

   // source and halving held from start-up; no write path reaches them
   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         osc_mode            <= ccd_pkg::OSC_XTAL_LOW;
         legacy_timing_halve <= 1'b0;
      end else if (state == ccd_pkg::ST_LOAD) begin
         osc_mode <= user_config_byte_one_in[ccd_pkg::OSC_LSB +:
                                             ccd_pkg::OSC_W];
         legacy_timing_halve <=
            user_config_byte_one_in[ccd_pkg::HALVE_BIT];
      end
   end

   // source-dependent pin and clock output qualification
   // power-down stands for a stopped oscillator: tick, machine cycle
   // and clock output freeze where they are and resume after
   always_comb begin
      crystal           = ccd_pkg::is_crystal(osc_mode);
      clock_out_allowed = (osc_mode == ccd_pkg::OSC_RC) ||
                          (osc_mode == ccd_pkg::OSC_EXT);
      clock_out_enable  = port2_mode_one[ccd_pkg::CLOCK_OUT_ENABLE_BIT];
      clock_out_on      = clock_out_enable && clock_out_allowed;
      running           = (state == ccd_pkg::ST_RUN) &&
                          !power_down_in;
   end

   // register map, byte wide, all reset to zero
   //   0x00 cpu_clock_divider_value: 0 runs at the oscillator rate,
   //        N divides by 2*(N+1); reloads at the next cpu clock wrap
   //   0x01 port2_mode_one: bit 4 clock_out_enable; other bits are
   //        kept for the rest of the port logic, no effect here
   //   0x02 status, read only:
   //        [2:0] oscillator source taken at start-up
   //        [3]   legacy halving in force
   //        [4]   clock output active on the pin
   //        [5]   clock output level
   //        [7:6] zero
   //   other offsets read zero and ignore writes
   // software registers; divider writable any time
   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         cpu_clock_divider_value <= ccd_pkg::RST_DIV;
         port2_mode_one          <= ccd_pkg::RST_PORT2_MODE_ONE;
      end else if (wr_in) begin
         if (addr_in == ccd_pkg::ADR_DIV) begin
            cpu_clock_divider_value <= wr_data_in;
         end
         if (addr_in == ccd_pkg::ADR_PORT2_MODE_ONE) begin
            port2_mode_one <= wr_data_in;
         end
      end
   end

   // status view of the block's own state
   // a live view, so it needs no write path and ignores writes
   always_comb begin
      status = ccd_pkg::RST_ZERO;
      status[ccd_pkg::ST_OSC_LSB +: ccd_pkg::OSC_W] = osc_mode;
      status[ccd_pkg::ST_HALVE]   = legacy_timing_halve;
      status[ccd_pkg::ST_CKO_ON]  = clock_out_on;
      status[ccd_pkg::ST_CKO_LVL] = clock_out_level;
   end

   // read mux; unmapped offsets read zero
   always_comb begin
      case (addr_in)
         ccd_pkg::ADR_DIV:  next_rd_data = cpu_clock_divider_value;
         ccd_pkg::ADR_PORT2_MODE_ONE: next_rd_data = port2_mode_one;
         ccd_pkg::ADR_STAT: next_rd_data = status;
         default:           next_rd_data = ccd_pkg::RST_ZERO;
      endcase
   end

   // read data stands only in the cycle after the strobe
   // zero otherwise, so stale data never lingers on the bus
   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         rd_data_out <= ccd_pkg::RST_ZERO;
      end else if (rd_in) begin
         rd_data_out <= next_rd_data;
      end else begin
         rd_data_out <= ccd_pkg::RST_ZERO;
      end
   end

   // mode register image for the rest of the port logic
   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         port2_mode_one_out <= ccd_pkg::RST_PORT2_MODE_ONE;
      end else begin
         port2_mode_one_out <= port2_mode_one;
      end
   end

   // cpu clock enable; halving folded into the period
   // the divider is handed over raw; the tick module keeps the
   // period it started with until the current cpu clock ends, so a
   // rewrite never shortens or stretches a clock already running
   ccd_cpu_tick #(
      .CNT_W (ccd_pkg::CNT_W)
   ) u_tick (
      .ref_clk_in (ref_clk_in),
      .rst_in     (rst_in),
      .run_in     (running),
      .div_in     (cpu_clock_divider_value),
      .halve_in   (legacy_timing_halve),
      .tick_out   (cpu_tick)
   );

   // core and peripherals share the halved tick
   always_comb begin
      cpu_clk_en_out    = cpu_tick;
      periph_clk_en_out = cpu_tick;
   end

   // machine cycle: six cpu clocks, twelve oscillator clocks halved
   // the marker lags the sixth tick by one oscillator clock;
   // peripherals counting machine cycles see the same halving
   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         mcyc_count        <= ccd_pkg::CNT3_ZERO;
         machine_cycle_out <= 1'b0;
      end else if (cpu_tick) begin
         if (mcyc_count == ccd_pkg::MCYC_LAST) begin
            mcyc_count        <= ccd_pkg::CNT3_ZERO;
            machine_cycle_out <= 1'b1;
         end else begin
            mcyc_count        <= mcyc_count + ccd_pkg::CNT3_ONE;
            machine_cycle_out <= 1'b0;
         end
      end else begin
         machine_cycle_out <= 1'b0;
      end
   end

   // clock output: toggle every third cpu clock, so one sixth;
   // idle does not gate it, only power-down stops the tick
   // disabling clears phase and level so a re-enable starts low
   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         cko_phase       <= ccd_pkg::CNT3_ZERO;
         clock_out_level <= 1'b0;
      end else if (!clock_out_on) begin
         cko_phase       <= ccd_pkg::CNT3_ZERO;
         clock_out_level <= 1'b0;
      end else if (cpu_tick) begin
         if (cko_phase == ccd_pkg::CKO_HALF_LAST) begin
            cko_phase       <= ccd_pkg::CNT3_ZERO;
            clock_out_level <= !clock_out_level;
         end else begin
            cko_phase <= cko_phase + ccd_pkg::CNT3_ONE;
         end
      end
   end

   // pin use by source:
   //   crystal      both pins cut off, readback zero
   //   rc           both pins are port pins, clock output may
   //                take osc_out_pin
   //   external     osc_in_pin is the clock input, read back only;
   //                osc_out_pin is a port pin or the clock output
   //   codes 5 to 7 no clock output, both pins are port pins
   // all pin outputs are registered, so they lag the mode by a cycle
   // osc_out_pin: clock output, port pin, or cut off for a crystal
   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         osc_out_pin_out    <= 1'b0;
         osc_out_pin_oe_out <= 1'b0;
         port2_bit0_out     <= 1'b0;
      end else if (crystal || state != ccd_pkg::ST_RUN) begin
         osc_out_pin_out    <= 1'b0;
         osc_out_pin_oe_out <= 1'b0;
         port2_bit0_out     <= 1'b0;
      end else if (clock_out_on) begin
         osc_out_pin_out    <= clock_out_level;
         osc_out_pin_oe_out <= 1'b1;
         port2_bit0_out     <= osc_out_pin_in;
      end else begin
         osc_out_pin_out    <= port2_bit0_drive_in;
         osc_out_pin_oe_out <= port2_bit0_oe_in;
         port2_bit0_out     <= osc_out_pin_in;
      end
   end

   // osc_in_pin: clock input for external mode, port pin for rc;
   // the input still reads back so software can watch the clock pin
   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         osc_in_pin_out    <= 1'b0;
         osc_in_pin_oe_out <= 1'b0;
         port2_bit1_out    <= 1'b0;
      end else if (crystal || state != ccd_pkg::ST_RUN) begin
         osc_in_pin_out    <= 1'b0;
         osc_in_pin_oe_out <= 1'b0;
         port2_bit1_out    <= 1'b0;
      end else if (osc_mode == ccd_pkg::OSC_EXT) begin
         osc_in_pin_out    <= 1'b0;
         osc_in_pin_oe_out <= 1'b0;
         port2_bit1_out    <= osc_in_pin_in;
      end else begin
         osc_in_pin_out    <= port2_bit1_drive_in;
         osc_in_pin_oe_out <= port2_bit1_oe_in;
         port2_bit1_out    <= osc_in_pin_in;
      end
   end

   // idle is accepted but changes nothing here; software turns the
   // clock output off before idle if it wants the saving
   logic idle_seen;
   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         idle_seen <= 1'b0;
      end else begin
         idle_seen <= idle_in && !clock_out_on;
      end
   end
endmodule : ccd_clock_ctrl
`default_nettype wire

// ===== rtl/ccd_cpu_tick.sv
// cpu clock enable generator with boundary-latched divider
`default_nettype none
module ccd_cpu_tick #(
   parameter int CNT_W = ccd_pkg::CNT_W
) (
   input  wire logic                      ref_clk_in,
   input  wire logic                      rst_in,
   input  wire logic                      run_in,
   input  wire logic [ccd_pkg::DATA_W-1:0] div_in,
   input  wire logic                      halve_in,
   output logic                           tick_out
);
   logic [CNT_W-1:0] count;
   logic [CNT_W-1:0] period;
   logic [CNT_W-1:0] next_period;

   // new divider or halving picked up only at a wrap
   always_comb begin
      next_period = ccd_pkg::cpu_period(div_in, halve_in);
   end

   // period reload at the boundary keeps every cpu clock whole
   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         count    <= '0;
         period   <= ccd_pkg::PERIOD_ONE;
         tick_out <= 1'b0;
      end else if (run_in) begin
         if (count >= period - ccd_pkg::PERIOD_ONE) begin
            count    <= '0;
            period   <= next_period;
            tick_out <= 1'b1;
         end else begin
            count    <= count + ccd_pkg::PERIOD_ONE;
            tick_out <= 1'b0;
         end
      end else begin
         tick_out <= 1'b0; // frozen, oscillator stopped
      end
   end
endmodule : ccd_cpu_tick
`default_nettype wire

// ===== rtl/ccd_pkg.sv
// constants and helpers for the cpu clock divider and clock output block
`default_nettype none
package ccd_pkg;
   // register port geometry
   localparam int ADDR_W = 8;
   localparam int DATA_W = 8;

   // register offsets
   localparam logic [ADDR_W-1:0] ADR_DIV  = 8'h00;
   localparam logic [ADDR_W-1:0] ADR_PORT2_MODE_ONE = 8'h01;
   localparam logic [ADDR_W-1:0] ADR_STAT = 8'h02;

   // reset values
   localparam logic [DATA_W-1:0] RST_DIV  = 8'h00;
   localparam logic [DATA_W-1:0] RST_PORT2_MODE_ONE = 8'h00;
   localparam logic [DATA_W-1:0] RST_ZERO = 8'h00;

   // port2_mode_one field: clock_out_enable
   localparam int CLOCK_OUT_ENABLE_BIT = 4;

   // user_config_byte_one fields
   localparam int OSC_LSB   = 0;
   localparam int OSC_W     = 3;
   localparam int HALVE_BIT = 3;

   // status register fields
   localparam int ST_OSC_LSB = 0;
   localparam int ST_HALVE   = 3;
   localparam int ST_CKO_ON  = 4;
   localparam int ST_CKO_LVL = 5;
   localparam int ST_PAD_W   = 2;

   // oscillator source codes
   localparam logic [OSC_W-1:0] OSC_XTAL_LOW = 3'h0;
   localparam logic [OSC_W-1:0] OSC_XTAL_MED = 3'h1;
   localparam logic [OSC_W-1:0] OSC_XTAL_HI  = 3'h2;
   localparam logic [OSC_W-1:0] OSC_RC       = 3'h3;
   localparam logic [OSC_W-1:0] OSC_EXT      = 3'h4;

   // divider arithmetic
   localparam int CNT_W = 11;
   localparam logic [CNT_W-1:0] PERIOD_ONE = 11'h001;
   localparam logic [CNT_W-1:0] PERIOD_ADD = 11'h002;

   // clock output: half period in cpu clocks, machine cycle length
   localparam logic [2:0] CKO_HALF_LAST = 3'h2;
   localparam logic [2:0] MCYC_LAST     = 3'h5;
   localparam logic [2:0] CNT3_ZERO     = 3'h0;
   localparam logic [2:0] CNT3_ONE      = 3'h1;

   // start-up sequencing, one-hot
   typedef enum logic [1:0] {
      ST_LOAD = 2'b01,
      ST_RUN  = 2'b10
   } ccd_state_t;

   // oscillator cycles per cpu clock for a divider value and halving
   function automatic logic [CNT_W-1:0] cpu_period(
      input logic [DATA_W-1:0] div,
      input logic              halve);
      logic [CNT_W-1:0] p;
      p = PERIOD_ONE;
      if (div != RST_ZERO) begin
         p = {2'b00, div, 1'b0} + PERIOD_ADD;
      end
      if (halve) begin
         p = {p[CNT_W-2:0], 1'b0};
      end
      return p;
   endfunction : cpu_period

   // crystal sources take both oscillator pins away from the port
   function automatic logic is_crystal(input logic [OSC_W-1:0] m);
      return (m == OSC_XTAL_LOW) || (m == OSC_XTAL_MED) ||
             (m == OSC_XTAL_HI);
   endfunction : is_crystal
endpackage : ccd_pkg
`default_nettype wire

// ===== verif/ccd_clock_ctrl_asserts.sv
// assertions on the clock divider top ports
`default_nettype none
module ccd_clock_ctrl_asserts (
   input wire logic       ref_clk_in,
   input wire logic       rst_in,
   input wire logic [7:0] user_config_byte_one_in,
   input wire logic [7:0] addr_in,
   input wire logic [7:0] wr_data_in,
   input wire logic       wr_in,
   input wire logic       rd_in,
   input wire logic [7:0] rd_data_out,
   input wire logic       cpu_clk_en_out,
   input wire logic       periph_clk_en_out,
   input wire logic       machine_cycle_out,
   input wire logic       port2_bit0_out,
   input wire logic       port2_bit0_oe_in,
   input wire logic       osc_out_pin_out,
   input wire logic       osc_out_pin_oe_out,
   input wire logic       osc_in_pin_oe_out,
   input wire logic [7:0] port2_mode_one_out
);
   logic [10:0] gap;   // cycles since last tick
   logic [2:0]  mc_n;  // ticks since last machine cycle
   logic [2:0]  co_n;  // ticks since last clock out edge
   logic        co_ok; // first edge after enable has no known phase
   logic        co_prev; // pin level one edge back
   logic        cko;
   logic [2:0]  src;
   assign cko = osc_out_pin_oe_out && port2_mode_one_out[4];
   assign src = user_config_byte_one_in[2:0];
   default clocking cb @(posedge ref_clk_in); endclocking
   default disable iff (rst_in);
   // tick spacing and ticks per machine cycle
   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         gap  <= 11'h000;
         mc_n <= 3'h0;
      end else begin
         gap  <= cpu_clk_en_out ? 11'h000 : gap + 11'h001;
         mc_n <= (machine_cycle_out ? 3'h0 : mc_n) + {2'h0, cpu_clk_en_out};
      end
   end
   // clock out half periods counted in ticks
   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         co_n    <= 3'h0;
         co_ok   <= 1'b0;
         co_prev <= 1'b0;
      end else begin
         co_prev <= osc_out_pin_out;
         if (!cko || osc_out_pin_out != co_prev) begin
            co_n  <= {2'h0, cpu_clk_en_out};
            co_ok <= cko;
         end else begin
            co_n <= co_n + {2'h0, cpu_clk_en_out};
         end
      end
   end
   property p_periph; periph_clk_en_out == cpu_clk_en_out; endproperty
   a_periph: assert property (p_periph) else $error("periph tick");
   property p_gap; gap < 11'h400; endproperty
   a_gap: assert property (p_gap) else $error("tick gap");
   property p_mcyc; machine_cycle_out |-> mc_n == 3'h6; endproperty
   a_mcyc: assert property (p_mcyc) else $error("machine cycle");
   property p_cko; cko && co_ok && $changed(osc_out_pin_out) |-> co_n == 3'h3;
   endproperty
   a_cko: assert property (p_cko) else $error("clock out rate");
   property p_xtal; src < 3'h3 |->
      !(osc_out_pin_oe_out || osc_in_pin_oe_out || port2_bit0_out); endproperty
   a_xtal: assert property (p_xtal) else $error("crystal pins");
   property p_p2m; wr_in && addr_in == ccd_pkg::ADR_PORT2_MODE_ONE |-> ##2
      port2_mode_one_out == $past(wr_data_in, 2); endproperty
   a_p2m: assert property (p_p2m) else $error("mode write");
   property p_stat; rd_in && addr_in == ccd_pkg::ADR_STAT |=>
      rd_data_out[3:0] == user_config_byte_one_in[3:0]; endproperty
   a_stat: assert property (p_stat) else $error("status read");
   property p_port; (src == ccd_pkg::OSC_EXT && !port2_mode_one_out[4]) [*4]
      |-> osc_out_pin_oe_out == $past(port2_bit0_oe_in); endproperty
   a_port: assert property (p_port) else $error("port pin");
endmodule : ccd_clock_ctrl_asserts
bind ccd_clock_ctrl ccd_clock_ctrl_asserts i_ccd_clock_ctrl_asserts (.*);
`default_nettype wire

// ===== verif/ccd_far_dev.sv
// far-side device watching the clock output pin
`default_nettype none
module ccd_far_dev (
   input  wire logic ref_clk_in,
   input  wire logic oe_in,
   input  wire logic drv_in,
   output logic      pin_out,
   output int        rises_out
);
   timeunit 1ns;
   timeprecision 1ns;
   logic last = 1'b0;
   int   rises = 0;
   assign rises_out = rises;
   // no pull on the pin: released, it shows a changing pattern
   assign pin_out = oe_in ? drv_in : ~last;
   // counts driven rising edges, as a synced device would
   always @(posedge ref_clk_in) begin
      if (oe_in && drv_in && !last) rises <= rises + 1;
      last <= pin_out;
   end
endmodule : ccd_far_dev
`default_nettype wire

// ===== verif/tb.sv
// self-checking bench for the cpu clock divider and clock output
`default_nettype none
module tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic       ref_clk_in = 1'b0, rst_in = 1'b1, wr_in = 1'b0, rd_in = 1'b0;
   logic       idle_in = 1'b0, power_down_in = 1'b0, osc_in_pin_in = 1'b0;
   logic       port2_bit0_drive_in = 1'b1, port2_bit0_oe_in = 1'b0;
   logic       port2_bit1_drive_in = 1'b1, port2_bit1_oe_in = 1'b0;
   logic [7:0] user_config_byte_one_in = 8'h03, addr_in = 8'h00;
   logic [7:0] wr_data_in = 8'h00, rd_data_out, port2_mode_one_out;
   logic       cpu_clk_en_out, periph_clk_en_out, machine_cycle_out;
   logic       port2_bit0_out, port2_bit1_out, osc_out_pin_in;
   logic       osc_out_pin_out, osc_out_pin_oe_out, osc_in_pin_out;
   logic       osc_in_pin_oe_out;
   int         n_fail = 0, total_checks = 0, rises, r, m;
   ccd_clock_ctrl i_ccd_clock_ctrl (.*);
   ccd_far_dev i_ccd_far_dev (.ref_clk_in, .oe_in(osc_out_pin_oe_out),
      .drv_in(osc_out_pin_out), .pin_out(osc_out_pin_in), .rises_out(rises));
   initial begin
      forever #10 ref_clk_in = ~ref_clk_in;
   end
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      total_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("mismatch at %0t: got %h, expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic cyc(input int n);
      repeat (n) @(posedge ref_clk_in);
   endtask : cyc
   // bus cycles: one strobe cycle, read data looked at the cycle after
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge ref_clk_in);
      {wr_in, addr_in, wr_data_in} <= {1'b1, a, d};
      @(posedge ref_clk_in);
      wr_in <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [7:0] d);
      @(posedge ref_clk_in);
      {rd_in, addr_in} <= {1'b1, a};
      @(posedge ref_clk_in);
      rd_in <= 1'b0;
      @(posedge ref_clk_in);
      chk(16'(rd_data_out), 16'(d));
   endtask : rd
   // config byte only counts at reset release
   task automatic boot(input logic [7:0] cfg);
      {rst_in, user_config_byte_one_in} <= {1'b1, cfg};
      cyc(8);
      rst_in <= 1'b0;
      cyc(4);
   endtask : boot
   // third tick spacing, so a pending divider change has landed
   task automatic per(input logic [15:0] p);
      int n;
      repeat (3) begin
         n = 0;
         do begin
            @(posedge ref_clk_in);
            n++;
         end while (cpu_clk_en_out !== 1'b1 && n < 1100);
      end
      chk(16'(n), p);
   endtask : per
   // clock out rises and machine cycles over a span
   task automatic span(input int len);
      r = rises;
      m = 0;
      repeat (len) begin
         @(posedge ref_clk_in);
         m += int'(machine_cycle_out);
      end
      r = rises - r;
   endtask : span
   task automatic t_div;
      boot(8'h03);
      rd(ccd_pkg::ADR_DIV, ccd_pkg::RST_DIV);
      rd(ccd_pkg::ADR_PORT2_MODE_ONE, ccd_pkg::RST_PORT2_MODE_ONE);
      wr(ccd_pkg::ADR_STAT, 8'hFF);
      rd(ccd_pkg::ADR_STAT, 8'h03);
      wr(8'h7F, 8'h55);
      rd(8'h7F, 8'h00);
      per(16'h0001);
      wr(ccd_pkg::ADR_DIV, 8'h01);
      per(16'h0004);
      wr(ccd_pkg::ADR_DIV, 8'hFF);
      per(16'h0200);
      wr(ccd_pkg::ADR_DIV, 8'h00);
      per(16'h0001);
   endtask : t_div
   task automatic t_halve;
      boot(8'h0B);
      per(16'h0002);
      span(120);
      chk(16'(m), 16'h000A);
      wr(ccd_pkg::ADR_DIV, 8'h01);
      per(16'h0008);
   endtask : t_halve
   // steady spans only: startup phase of the output is not pinned down
   task automatic t_cko;
      boot(8'h03);
      wr(ccd_pkg::ADR_PORT2_MODE_ONE, 8'h10);
      idle_in <= 1'b1;
      cyc(12);
      span(120);
      chk(16'(r), 16'h0014);
      power_down_in <= 1'b1;
      cyc(4);
      span(60);
      chk(16'(r), 16'h0000);
      chk(16'(m), 16'h0000);
      power_down_in <= 1'b0;
      wr(ccd_pkg::ADR_PORT2_MODE_ONE, 8'h00);
      wr(ccd_pkg::ADR_DIV, 8'h01);
      wr(ccd_pkg::ADR_PORT2_MODE_ONE, 8'h10);
      cyc(40);
      span(240);
      chk(16'(r), 16'h000A);
      wr(ccd_pkg::ADR_PORT2_MODE_ONE, 8'h00);
      idle_in <= 1'b0;
      cyc(3);
      chk(16'(osc_out_pin_oe_out), 16'h0000);
   endtask : t_cko
   task automatic t_xtal;
      {port2_bit0_oe_in, port2_bit1_oe_in} <= 2'b11;
      for (int s = 0; s < 3; s++) begin
         boot(8'(s));
         wr(ccd_pkg::ADR_PORT2_MODE_ONE, 8'h10);
         cyc(12);
         chk(16'({osc_out_pin_oe_out, osc_in_pin_oe_out}), 16'h0000);
         chk(16'({port2_bit0_out, port2_bit1_out}), 16'h0000);
      end
   endtask : t_xtal
   task automatic t_ext;
      osc_in_pin_in <= 1'b1;
      boot(8'h04);
      chk(16'({osc_in_pin_oe_out, osc_in_pin_out}), 16'h0000);
      chk(16'(port2_bit1_out), 16'h0001);
      chk(16'({osc_out_pin_oe_out, port2_bit0_out}), 16'h0003);
      port2_bit0_drive_in <= 1'b0;
      cyc(4);
      chk(16'({osc_out_pin_out, port2_bit0_out}), 16'h0000);
      wr(ccd_pkg::ADR_PORT2_MODE_ONE, 8'h10);
      cyc(12);
      span(120);
      chk(16'(r), 16'h0014);
   endtask : t_ext
   task automatic summarize;
      $display("checks %0d, mismatches %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : summarize
   // whole run is a few thousand cycles
   initial begin
      repeat (20000) @(posedge ref_clk_in);
      n_fail++;
      summarize();
   end
   initial begin
      t_div();
      t_halve();
      t_cko();
      t_xtal();
      t_ext();
      summarize();
   end
endmodule : tb
`default_nettype wire
